/* File: tb/pmic_regs_assertions.sv */
/* Port checker for the register bank. Assumes it is bound to the design top. */
`timescale 1ns/10ps
module pmic_regs_checker (
  input wire clk_sys, input wire reset, input wire [6:0] regAddr, input wire regWrite,
  input wire [7:0] regWriteData, input wire regRead, input wire [7:0] regReadData,
  input wire regReadValid, input wire [15:0] wheel_pwm_level, input wire fastShutdown,
  input wire [1:0] illum_conv1_bw_boost, input wire [1:0] illum_conv2_bw_boost,
  input wire focus_conv_pgood_err, input wire focus_conv_overvolt_err
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_hi; regWrite && regAddr == 7'h1c |=> wheel_pwm_level[15:8] == $past(regWriteData); endproperty
  a_hi: assert property (p_hi) else $error("High level byte wrong.");
  property p_lo; regWrite && regAddr == 7'h1b |=> wheel_pwm_level[7:0] == $past(regWriteData); endproperty
  a_lo: assert property (p_lo) else $error("Low level byte wrong.");
  property p_bw; regWrite && regAddr == 7'h25 |=>
    {illum_conv1_bw_boost, illum_conv2_bw_boost} == $past(regWriteData[3:0]); endproperty
  a_bw: assert property (p_bw) else $error("Boost fields wrong.");
  property p_cap; regRead && regAddr == 7'h26 |=> regReadData == 8'hdf; endproperty
  a_cap: assert property (p_cap) else $error("Capability read wrong.");
  property p_pg; regRead && regAddr == 7'h27 |=>
    regReadData[1:0] == 2'b00 && regReadData[7] == $past(focus_conv_pgood_err, 2); endproperty
  a_pg: assert property (p_pg) else $error("Power good read wrong.");
  property p_ov; regRead && regAddr == 7'h28 |=> regReadData[7] == $past(focus_conv_overvolt_err, 2);
  endproperty
  a_ov: assert property (p_ov) else $error("Overvoltage read wrong.");
  property p_bz; regRead && regAddr == 7'h25 |=> regReadData[7:4] == 4'h0; endproperty
  a_bz: assert property (p_bz) else $error("Boost reserved bits not zero.");
  property p_sd; focus_conv_pgood_err || focus_conv_overvolt_err |-> !fastShutdown [*3];
  endproperty
  a_sd: assert property (p_sd) else $error("Shutdown raised.");
  property p_vl; regReadValid == $past(regRead); endproperty
  a_vl: assert property (p_vl) else $error("Read valid misplaced.");
endmodule // pmic_regs_checker
bind pmic_config_status_regs pmic_regs_checker pmic_regs_checker_i (.clk_sys(clk_sys),
  .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
  .regRead(regRead), .regReadData(regReadData), .regReadValid(regReadValid),
  .wheel_pwm_level(wheel_pwm_level), .fastShutdown(fastShutdown),
  .illum_conv1_bw_boost(illum_conv1_bw_boost), .illum_conv2_bw_boost(illum_conv2_bw_boost),
  .focus_conv_pgood_err(focus_conv_pgood_err), .focus_conv_overvolt_err(focus_conv_overvolt_err));

/* File: tb/tb_pmic_config_status_regs.sv */
/* Random and corner tests of the register bank. Assumes the checker file is compiled too. */
`timescale 1ns/10ps
module tb_pmic_config_status_regs;
  reg clk_sys = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  reg [6:0] regAddr = 7'h00;
  reg [7:0] regWriteData = 8'h00, d;
  reg [9:0] flt = 10'h000;
  reg [31:0] rnd;
  wire [7:0] regReadData;
  wire regReadValid, fastShutdown;
  wire [15:0] lvl;
  wire [1:0] bw1, bw2;
  integer miscompares = 0, checked = 0, i;
  always #2 clk_sys = ~clk_sys;
  pmic_config_status_regs pmic_config_status_regs_i (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
    .focus_conv_pgood_err(flt[9]), .aux_conv1_pgood_err(flt[8]), .aux_conv2_pgood_err(flt[7]),
    .illum_conv1_pgood_err(flt[6]), .illum_conv2_pgood_err(flt[5]),
    .focus_conv_overvolt_err(flt[4]), .aux_conv1_overvolt_err(flt[3]),
    .aux_conv2_overvolt_err(flt[2]), .illum_conv1_overvolt_err(flt[1]),
    .illum_conv2_overvolt_err(flt[0]), .regReadData(regReadData), .regReadValid(regReadValid),
    .wheel_pwm_level(lvl), .illum_conv1_bw_boost(bw1), .illum_conv2_bw_boost(bw2),
    .fastShutdown(fastShutdown));
  function [7:0] stat(input [4:0] f);
    stat = {f[4:2], 1'b0, f[1:0], 2'b00};
  endfunction
  task print_verdict;
    begin
      if (miscompares == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [79:0] nm, input logic [15:0] e, input logic [15:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] v);
    begin
      @(negedge clk_sys);
      {regAddr, regWriteData, regWrite} = {a, v, 1'b1};
      @(negedge clk_sys);
      regWrite = 1'b0;
    end
  endtask
  task rd(input [6:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      {regAddr, regRead} = {a, 1'b1};
      @(negedge clk_sys);
      regRead = 1'b0;
      chk("valid", 16'h0001, {15'h0, regReadValid});
      chk("readData", {8'h00, e}, {8'h00, regReadData});
    end
  endtask
  initial begin
    rnd = $urandom(32'h3ebde3e6);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    rd(7'h1b, 8'h00);
    rd(7'h25, 8'h00);
    rd(7'h26, 8'hdf);
    rd(7'h27, 8'h00);
    rd(7'h28, 8'h00);
    rd(7'h7f, 8'h00);
    for (i = 0; i < 24; i = i + 1) begin
      rnd = $urandom;
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd[7:0];
      wr(7'h1b, d);
      wr(7'h1c, ~d);
      chk("level", {~d, d}, lvl);
      rd(7'h1c, ~d);
      wr(7'h25, d);
      chk("boost", {12'h000, d[3:0]}, {12'h000, bw1, bw2});
      rd(7'h25, d & 8'h0f);
      wr(7'h26, d);
      wr(7'h27, d);
      wr(7'h28, d);
      rd(7'h26, 8'hdf);
      flt = (i == 0) ? 10'h3ff : rnd[17:8];
      rd(7'h27, stat(flt[9:5]));
      rd(7'h28, stat(flt[4:0]));
      chk("shutdown", 16'h0000, {15'h0, fastShutdown});
    end
    @(negedge clk_sys) reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    chk("level", 16'h0000, lvl);
    chk("boost", 16'h0000, {12'h000, bw1, bw2});
    rd(7'h1c, 8'h00);
    rd(7'h26, 8'hdf);
    print_verdict;
  end
  initial begin
    #40000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // tb_pmic_config_status_regs

/* File: verilog/pmic_config_status_regs.v */
/*
  Configuration and fault-status register bank of the power manager:
  wheel PWM level, converter bandwidth boost, capability and fault flags.
  Assumes a synchronous register port on clk_sys; a write strobe and a
  read strobe last one cycle each; fault inputs are synchronous levels.
*/
`timescale 1ns/10ps
`include "pmic_regs_defines.vh"

module pmic_config_status_regs #(
  parameter [7:0] CAPABILITY_INIT = `RST_CAPABILITY
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire [6:0]  regAddr,
  input  wire        regWrite,
  input  wire [7:0]  regWriteData,
  input  wire        regRead,
  input  wire        focus_conv_pgood_err,
  input  wire        aux_conv1_pgood_err,
  input  wire        aux_conv2_pgood_err,
  input  wire        illum_conv1_pgood_err,
  input  wire        illum_conv2_pgood_err,
  input  wire        focus_conv_overvolt_err,
  input  wire        aux_conv1_overvolt_err,
  input  wire        aux_conv2_overvolt_err,
  input  wire        illum_conv1_overvolt_err,
  input  wire        illum_conv2_overvolt_err,
  output reg  [7:0]  regReadData,
  output reg         regReadValid,
  output reg  [15:0] wheel_pwm_level,
  output reg  [1:0]  illum_conv1_bw_boost,
  output reg  [1:0]  illum_conv2_bw_boost,
  output reg         fastShutdown
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire       selWheelLow;
  wire       selWheelHigh;
  wire       selBwSelect;
  wire       selCapability;
  wire       selPgood;
  wire       selOvervolt;

  // Compares the register address with one register offset.
  function addrHit;
    input [6:0] addr;
    input [6:0] offset;
    begin
      addrHit = (addr == offset);
    end
  endfunction

  assign selWheelLow   = addrHit(regAddr, `OFF_WHEEL_PWM_LOW);
  assign selWheelHigh  = addrHit(regAddr, `OFF_WHEEL_PWM_HIGH);
  assign selBwSelect   = addrHit(regAddr, `OFF_BW_SELECT);
  assign selCapability = addrHit(regAddr, `OFF_CAPABILITY);
  assign selPgood      = addrHit(regAddr, `OFF_PGOOD_STATUS);
  assign selOvervolt   = addrHit(regAddr, `OFF_OVERVOLT_STATUS);

  // ----------------------------------------------------------------------
  // Fault inputs
  // ----------------------------------------------------------------------
  wire [7:0] pgoodLive;
  wire [7:0] overvoltLive;

  // Places the five fault levels at their status bit positions.
  function [7:0] faultByte;
    input focus;
    input aux1;
    input aux2;
    input illum1;
    input illum2;
    begin
      faultByte = `READ_ZERO;
      faultByte[`BIT_FOCUS] = focus;
      faultByte[`BIT_AUX1] = aux1;
      faultByte[`BIT_AUX2] = aux2;
      faultByte[`BIT_ILLUM1] = illum1;
      faultByte[`BIT_ILLUM2] = illum2;
    end
  endfunction

  assign pgoodLive = faultByte(focus_conv_pgood_err, aux_conv1_pgood_err, aux_conv2_pgood_err,
                               illum_conv1_pgood_err, illum_conv2_pgood_err);
  assign overvoltLive = faultByte(focus_conv_overvolt_err, aux_conv1_overvolt_err,
                                  aux_conv2_overvolt_err, illum_conv1_overvolt_err,
                                  illum_conv2_overvolt_err);

  // ----------------------------------------------------------------------
  // Wheel level and bandwidth boost, next values
  // ----------------------------------------------------------------------
  reg  [7:0] wheelLow_d;
  reg  [7:0] wheelHigh_d;
  reg  [1:0] conv1Boost_d;
  reg  [1:0] conv2Boost_d;

  // Each byte of the level is written on its own; nothing is latched.
  always @* begin
    wheelLow_d   = wheel_pwm_level[7:0];
    wheelHigh_d  = wheel_pwm_level[15:8];
    conv1Boost_d = illum_conv1_bw_boost;
    conv2Boost_d = illum_conv2_bw_boost;
    if (regWrite) begin
      if (selWheelLow) begin
        wheelLow_d = regWriteData;
      end
      if (selWheelHigh) begin
        wheelHigh_d = regWriteData;
      end
      if (selBwSelect) begin
        conv1Boost_d = regWriteData[`BW_CONV1_HI:`BW_CONV1_LO];
        conv2Boost_d = regWriteData[`BW_CONV2_HI:`BW_CONV2_LO];
      end
    end
  end

  // The level drives a PWM whose average is code * 5 V / 65536.
  always @(posedge clk_sys) begin
    if (reset) begin
      wheel_pwm_level      <= `RST_PWM_LEVEL;
      illum_conv1_bw_boost <= `RST_BW;
      illum_conv2_bw_boost <= `RST_BW;
    end else begin
      wheel_pwm_level      <= {wheelHigh_d, wheelLow_d};
      illum_conv1_bw_boost <= conv1Boost_d;
      illum_conv2_bw_boost <= conv2Boost_d;
    end
  end

  // ----------------------------------------------------------------------
  // Capability and fault status
  // ----------------------------------------------------------------------
  reg  [7:0] capability_q;
  reg  [7:0] pgoodStatus_q;
  reg  [7:0] overvoltStatus_q;
  reg  [7:0] pgoodStatus_d;
  reg  [7:0] overvoltStatus_d;

  // Status follows the fault levels one cycle late; no host write reaches it.
  always @* begin
    pgoodStatus_d    = pgoodLive & `STATUS_MASK;
    overvoltStatus_d = overvoltLive & `STATUS_MASK;
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      capability_q     <= CAPABILITY_INIT;
      pgoodStatus_q    <= `RST_BYTE;
      overvoltStatus_q <= `RST_BYTE;
    end else begin
      capability_q     <= CAPABILITY_INIT;
      pgoodStatus_q    <= pgoodStatus_d;
      overvoltStatus_q <= overvoltStatus_d;
    end
  end

  // None of these faults may start the fast shutdown sequence.
  always @(posedge clk_sys) begin
    if (reset) begin
      fastShutdown <= 1'b0;
    end else begin
      fastShutdown <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  reg  [7:0] readData_d;
  reg  [7:0] readHold_d;
  reg        readValid_d;

  always @* begin
    case (regAddr)
      `OFF_WHEEL_PWM_LOW:   readData_d = wheel_pwm_level[7:0];
      `OFF_WHEEL_PWM_HIGH:  readData_d = wheel_pwm_level[15:8];
      `OFF_BW_SELECT:       readData_d = {`BW_RESERVED_ZERO, illum_conv1_bw_boost,
                                          illum_conv2_bw_boost};
      `OFF_CAPABILITY:      readData_d = capability_q;
      `OFF_PGOOD_STATUS:    readData_d = pgoodStatus_q;
      `OFF_OVERVOLT_STATUS: readData_d = overvoltStatus_q;
      default:              readData_d = `READ_ZERO;
    endcase
  end

  // Read data holds its value until the next read strobe.
  always @* begin
    readValid_d = regRead;
    readHold_d  = regReadData;
    if (regRead) begin
      readHold_d = readData_d;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      regReadData  <= `READ_ZERO;
      regReadValid <= 1'b0;
    end else begin
      regReadData  <= readHold_d;
      regReadValid <= readValid_d;
    end
  end

endmodule // pmic_config_status_regs

/* File: verilog/pmic_regs_defines.vh */
/*
  Register offsets, field positions, reset values and constants for the
  configuration and fault-status register bank.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PMIC_REGS_DEFINES_VH
`define PMIC_REGS_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_WIDTH          7
`define OFF_WHEEL_PWM_LOW   7'h1b
`define OFF_WHEEL_PWM_HIGH  7'h1c
`define OFF_BW_SELECT       7'h25
`define OFF_CAPABILITY      7'h26
`define OFF_PGOOD_STATUS    7'h27
`define OFF_OVERVOLT_STATUS 7'h28

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_PWM_LEVEL       16'h0000
`define RST_CAPABILITY      8'hdf
`define RST_BW              2'h0
`define READ_ZERO           8'h00
`define BW_RESERVED_ZERO    4'h0
`define STATUS_MASK         8'hec

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BW_CONV1_HI         3
`define BW_CONV1_LO         2
`define BW_CONV2_HI         1
`define BW_CONV2_LO         0
`define BIT_FOCUS           7
`define BIT_AUX1            6
`define BIT_AUX2            5
`define BIT_ILLUM1          3
`define BIT_ILLUM2          2

// ----------------------------------------------------------------------
// Wheel level scale: 5 V full scale over 16 bits, about 76.294 uV a step
// ----------------------------------------------------------------------
`define PWM_STEP_UV_X1000   76294
`define PWM_FULL_SCALE_MV   5000

`endif
